// File: rtl/bls_sequencer.sv
// backlight driver operating-state sequencer
// assumes fault comparator levels on sys_clk, async enable/brightness pins
// Functional notes
// [RL1] standby once supply above rising undervoltage
// [RL2] enable high wakes regulator, enters soft start
// [RL3] enable low over 50 us: standby
// [RL4] soft start turns on line switch
// [RL5] soft start lasts 65 ms then boost
// [RL6] start states watch only four faults
// [RL7] boost start: converter on, reduced limit
// [RL8] 50 ms boost, check shorts, then normal
// [RL9] normal: sinks follow brightness input
// [RL10] normal: all faults including string faults
// [RL11] fault released entering normal after recovery
// [RL12] non-string fault: recovery, all power off
// [RL13] after 100 ms restart if enabled
// [RL14] fault output low during recovery
// [RL15] string fault disables only that string
// [RL16] short enable pulse clears string fault
// [RL17] synchronise inputs, timers restart per state
// [RL18] undervoltage in powered states resets sequencer
`timescale 1ns/1ps
module bls_sequencer
    import bls_pkg::*;
#(
    parameter int unsigned STRINGS       = 4,
    parameter int unsigned SOFT_CYCLES   = SOFT_START_CYC,
    parameter int unsigned BOOST_CYCLES  = BOOST_START_CYC,
    parameter int unsigned RECOV_CYCLES  = RECOVERY_CYC,
    parameter int unsigned EN_LOW_CYCLES = EN_LOW_CYC
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               supply_above_uvlo,
    input  wire logic               enable_and_io_supply_input,
    input  wire logic               brightness_pwm,
    input  bls_faults_t             faults,
    input  wire logic [STRINGS-1:0] string_grounded,
    input  wire logic [STRINGS-1:0] string_open_fault,
    input  wire logic [STRINGS-1:0] string_short_fault,
    output bls_power_t              power,
    output logic [STRINGS-1:0]      sink_on,
    output logic [STRINGS-1:0]      string_in_loop,
    output logic                    fault_out,
    output logic                    fault_oe_n,
    output bls_state_t              state
);

    // =====================================================================
    // elaboration checks
    if (STRINGS < 1 || STRINGS > 8) begin : g_bad_strings
        $error("STRINGS out of range");
    end
    if (SOFT_CYCLES < 1 || SOFT_CYCLES >= (1 << TIMER_W)) begin : g_bad_soft
        $error("bad soft");
    end
    if (BOOST_CYCLES < 1 || BOOST_CYCLES >= (1 << TIMER_W)) begin : g_bad_boost
        $error("bad boost");
    end
    if (RECOV_CYCLES < 1 || RECOV_CYCLES >= (1 << TIMER_W)) begin : g_bad_recov
        $error("bad recov");
    end
    if (EN_LOW_CYCLES < 1 || EN_LOW_CYCLES >= (1 << TIMER_W)) begin : g_bad_en
        $error("bad en");
    end
    if (SYNC_STAGES != 3) begin : g_bad_sync
        $error("synchroniser needs three stages");
    end

    // =====================================================================
    // helpers
    // dwell length in cycles to last count value
    function automatic logic [TIMER_W-1:0] cyc_limit(input int unsigned cycles);
        return TIMER_W'(cycles - 1);
    endfunction

    // states in which the power stage may run
    function automatic logic powered(input bls_state_t s);
        return s != BLS_OFF && s != BLS_STANDBY;
    endfunction

    // =====================================================================
    // input synchronisers
    logic en_s;
    logic pwm_s;
    logic uv_s;

    bls_sync u_sync_en (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (enable_and_io_supply_input),
        .sync_out (en_s)
    ); // RL17
    bls_sync u_sync_pwm (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (brightness_pwm),
        .sync_out (pwm_s)
    ); // RL17
    bls_sync u_sync_uv (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (supply_above_uvlo),
        .sync_out (uv_s)
    );

    // =====================================================================
    // state timers
    bls_state_t           state_q;
    bls_state_t           state_d;
    logic                 entry;
    logic [TIMER_W-1:0]   limit;
    logic                 dwell_done;
    logic                 en_low_done;
    logic                 en_restart;

    assign entry      = (state_d != state_q);
    assign en_restart = en_s;

    always_comb begin
        unique case (state_q)
            BLS_SOFT_START:  limit = cyc_limit(SOFT_CYCLES);
            BLS_BOOST_START: limit = cyc_limit(BOOST_CYCLES);
            BLS_RECOVERY:    limit = cyc_limit(RECOV_CYCLES);
            default:         limit = '1;
        endcase
    end

    bls_timer u_dwell (
        .sys_clk (sys_clk),
        .rst     (rst | entry),
        .restart (entry),
        .limit   (limit),
        .expired (dwell_done)
    ); // RL17
    bls_timer u_en_low (
        .sys_clk (sys_clk),
        .rst     (rst),
        .restart (en_restart),
        .limit   (cyc_limit(EN_LOW_CYCLES)),
        .expired (en_low_done)
    );

    // =====================================================================
    // fault classification
    logic start_fault;
    logic normal_fault;
    logic string_fault;

    always_comb begin
        start_fault  = faults.input_overvoltage_fault
                     | faults.input_undervoltage_fault
                     | faults.switch_node_overvoltage_fault
                     | faults.thermal_shutdown_fault; // RL6
        normal_fault = start_fault | faults.boost_overvoltage_fault; // RL10
        string_fault = |(string_open_fault | string_short_fault); // RL10
    end

    // =====================================================================
    // state and string bookkeeping
    logic [STRINGS-1:0] disabled_q;
    logic [STRINGS-1:0] disabled_d;
    logic               led_latch_q;
    logic               led_latch_d;
    logic               recovered_q;
    logic               recovered_d;
    logic               fault_low_q;
    logic               fault_low_d;

    always_comb begin
        state_d     = state_q;
        disabled_d  = disabled_q;
        led_latch_d = led_latch_q;
        recovered_d = recovered_q;
        unique case (state_q)
            BLS_OFF: begin
                if (uv_s) state_d = BLS_STANDBY; // RL1
            end
            BLS_STANDBY: begin
                disabled_d  = '0;
                led_latch_d = 1'b0;
                if (en_s) state_d = BLS_SOFT_START; // RL2
            end
            BLS_SOFT_START: begin
                if (start_fault) begin
                    state_d = BLS_RECOVERY; // RL12
                end else if (dwell_done) begin
                    state_d = BLS_BOOST_START; // RL5
                end
            end
            BLS_BOOST_START: begin
                if (start_fault) begin
                    state_d = BLS_RECOVERY; // RL12
                end else if (dwell_done) begin
                    disabled_d = string_grounded; // RL8
                    state_d    = BLS_NORMAL; // RL8
                    if (recovered_q) led_latch_d = 1'b0; // RL11
                end
            end
            BLS_NORMAL: begin
                if (normal_fault) begin
                    state_d = BLS_RECOVERY; // RL12
                end else begin
                    disabled_d = disabled_q | string_open_fault
                               | string_short_fault; // RL15
                    if (string_fault) led_latch_d = 1'b1; // RL15
                    else if (!en_s) led_latch_d = 1'b0; // RL16
                    recovered_d = 1'b0; // RL11
                end
            end
            BLS_RECOVERY: begin
                recovered_d = 1'b1;
                if (dwell_done) begin
                    state_d = en_s ? BLS_SOFT_START : BLS_STANDBY; // RL13
                end
            end
        endcase
        if (powered(state_q) && en_low_done && !en_s) begin
            state_d = BLS_STANDBY; // RL3
        end
        if (state_q != BLS_OFF && !uv_s) begin
            state_d = BLS_OFF; // RL18
        end
        fault_low_d = (state_d == BLS_RECOVERY) // RL14
                    | (state_d == BLS_NORMAL && led_latch_d); // RL15
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q     <= BLS_OFF;
            disabled_q  <= '0;
            led_latch_q <= 1'b0;
            recovered_q <= 1'b0;
            fault_low_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            disabled_q  <= disabled_d;
            led_latch_q <= led_latch_d;
            recovered_q <= recovered_d;
            fault_low_q <= fault_low_d;
        end
    end

    // =====================================================================
    // registered outputs
    bls_power_t         power_q;
    bls_power_t         power_d;
    logic [STRINGS-1:0] sink_q;
    logic [STRINGS-1:0] sink_d;
    logic [STRINGS-1:0] loop_q;
    logic [STRINGS-1:0] loop_d;
    logic               fault_data_q;

    always_comb begin
        power_d = '0;
        sink_d  = '0;
        loop_d  = ~disabled_d;
        unique case (state_d)
            BLS_SOFT_START: begin
                power_d.regulator_on   = 1'b1; // RL2
                power_d.line_switch_on = 1'b1; // RL4
            end
            BLS_BOOST_START: begin
                power_d.regulator_on   = 1'b1;
                power_d.line_switch_on = 1'b1;
                power_d.converter_on   = 1'b1; // RL7
                power_d.reduced_limit  = 1'b1; // RL7
            end
            BLS_NORMAL: begin
                power_d.regulator_on   = 1'b1;
                power_d.line_switch_on = 1'b1;
                power_d.converter_on   = 1'b1;
                power_d.short_check    = (state_q == BLS_BOOST_START); // RL8
                if (pwm_s && en_s) sink_d = ~disabled_d; // RL9
            end
            default: begin
                power_d = '0; // RL12
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            power_q      <= '0;
            sink_q       <= '0;
            loop_q       <= '1;
            fault_data_q <= 1'b0;
        end else begin
            // open-drain data: the pin only ever pulls low
            fault_data_q <= 1'b0;
            power_q <= power_d;
            sink_q  <= sink_d;
            loop_q  <= loop_d;
        end
    end

    assign power          = power_q;
    assign sink_on        = sink_q;
    assign string_in_loop = loop_q;
    assign fault_out      = fault_data_q;
    assign fault_oe_n     = ~fault_low_q;
    assign state          = state_q;

endmodule

// File: include/bls_pkg.sv
// package for the backlight state sequencer: states, fault bundle, timing
// assumes a single 40 MHz system clock
package bls_pkg;

    // =====================================================================
    // clock and timing
    localparam int unsigned CLK_HZ           = 40_000_000;
    localparam int unsigned SOFT_START_MS    = 65;
    localparam int unsigned BOOST_START_MS   = 50;
    localparam int unsigned RECOVERY_MS      = 100;
    localparam int unsigned EN_LOW_US        = 50;
    localparam int unsigned SOFT_START_CYC   = CLK_HZ / 1000 * SOFT_START_MS;
    localparam int unsigned BOOST_START_CYC  = CLK_HZ / 1000 * BOOST_START_MS;
    localparam int unsigned RECOVERY_CYC     = CLK_HZ / 1000 * RECOVERY_MS;
    localparam int unsigned EN_LOW_CYC       = CLK_HZ / 1_000_000 * EN_LOW_US;
    localparam int unsigned TIMER_W          = 24;
    localparam int unsigned SYNC_STAGES      = 3;

    // =====================================================================
    // sequencer states
    typedef enum logic [2:0] {
        BLS_OFF,
        BLS_STANDBY,
        BLS_SOFT_START,
        BLS_BOOST_START,
        BLS_NORMAL,
        BLS_RECOVERY
    } bls_state_t;

    // =====================================================================
    // fault comparator inputs
    typedef struct packed {
        logic input_overvoltage_fault;
        logic input_undervoltage_fault;
        logic switch_node_overvoltage_fault;
        logic thermal_shutdown_fault;
        logic boost_overvoltage_fault;
    } bls_faults_t;

    // power stage controls
    typedef struct packed {
        logic regulator_on;
        logic line_switch_on;
        logic converter_on;
        logic reduced_limit;
        logic short_check;
    } bls_power_t;

endpackage

// File: rtl/bls_sync.sv
// three-flop input synchroniser with agreement filter
// assumes input is asynchronous to sys_clk
`timescale 1ns/1ps
module bls_sync
    import bls_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);

    logic [SYNC_STAGES-1:0] stage_q;
    logic [SYNC_STAGES-1:0] stage_d;
    logic                   out_q;
    logic                   out_d;

    // =====================================================================
    // next values
    always_comb begin
        stage_d = {stage_q[SYNC_STAGES-2:0], async_in};
        out_d   = out_q;
        if (stage_q[1] == stage_q[2]) begin
            out_d = stage_q[2];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stage_q <= '0;
            out_q   <= 1'b0;
        end else begin
            stage_q <= stage_d;
            out_q   <= out_d;
        end
    end

    assign sync_out = out_q;

endmodule

// File: rtl/bls_timer.sv
// dwell timer: clears on restart, flags when count reached
// assumes restart pulses on state entry
`timescale 1ns/1ps
module bls_timer
    import bls_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               restart,
    input  wire logic [TIMER_W-1:0] limit,
    output logic                    expired
);

    logic [TIMER_W-1:0] count_q;
    logic [TIMER_W-1:0] count_d;

    // =====================================================================
    // counter
    always_comb begin
        count_d = count_q;
        if (restart) begin
            count_d = '0;
        end else if (count_q != limit) begin
            count_d = count_q + TIMER_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // not gated by restart: the caller derives restart from this flag
    assign expired = (count_q == limit);

endmodule

// File: test/bls_sequencer_checker.sv
// checker: dwell lengths, power and fault pin relations of the sequencer
// assumes binding into bls_sequencer with shortened dwell counts
`timescale 1ns/1ps
module bls_sequencer_checker
    import bls_pkg::*;
#(
    parameter int unsigned STRINGS       = 4,
    parameter int unsigned SOFT_CYCLES   = 20,
    parameter int unsigned BOOST_CYCLES  = 20,
    parameter int unsigned RECOV_CYCLES  = 30,
    parameter int unsigned EN_LOW_CYCLES = 8
) (
    input wire logic               sys_clk,
    input wire logic               rst,
    input wire logic               supply_above_uvlo,
    input wire logic               enable_and_io_supply_input,
    input wire logic               brightness_pwm,
    input bls_faults_t             faults,
    input bls_power_t              power,
    input wire logic [STRINGS-1:0] sink_on,
    input wire logic               fault_oe_n,
    input bls_state_t              state
);
    // =====================================================
    // dwell and enable-low counters
    bls_state_t prev_q;
    logic [7:0] dwell_q, dwell_d, enl_q, enl_d;
    always_comb begin
        dwell_d = (state != prev_q) ? 8'h00 : dwell_q + 8'h01;
        enl_d   = enable_and_io_supply_input ? 8'h00 : enl_q + {7'h00, enl_q != 8'hFF};
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prev_q  <= BLS_OFF;
            dwell_q <= 8'h00;
            enl_q   <= 8'h00;
        end else begin
            prev_q  <= state;
            dwell_q <= dwell_d;
            enl_q   <= enl_d;
        end
    end
    // =====================================================
    // properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_pwm_low;
        (state == BLS_NORMAL && !brightness_pwm) [*6];
    endsequence
    sequence s_supply_low;
        (!supply_above_uvlo) [*6];
    endsequence
    property p_off_exit;
        prev_q == BLS_OFF |-> state inside {BLS_OFF, BLS_STANDBY};
    endproperty
    property p_soft_power;
        state == BLS_SOFT_START |-> power.line_switch_on && power.regulator_on;
    endproperty
    property p_soft_len;
        state == BLS_BOOST_START && prev_q == BLS_SOFT_START
            |-> dwell_q inside {[SOFT_CYCLES-2:SOFT_CYCLES]};
    endproperty
    property p_boost_power;
        state == BLS_BOOST_START |-> power.converter_on && power.reduced_limit;
    endproperty
    property p_boost_len;
        state == BLS_NORMAL && prev_q == BLS_BOOST_START
            |-> dwell_q inside {[BOOST_CYCLES-2:BOOST_CYCLES]} && fault_oe_n
                && power.short_check;
    endproperty
    property p_start_cause;
        state == BLS_RECOVERY && prev_q inside {BLS_SOFT_START, BLS_BOOST_START}
            |-> $past(faults[4:1]) != 4'h0 || $past(faults[4:1], 2) != 4'h0;
    endproperty
    property p_rec_off;
        state == BLS_RECOVERY
            |-> !power.line_switch_on && !power.converter_on && sink_on == '0 && !fault_oe_n;
    endproperty
    property p_rec_len;
        state == BLS_SOFT_START && prev_q == BLS_RECOVERY
            |-> dwell_q inside {[RECOV_CYCLES-2:RECOV_CYCLES]};
    endproperty
    property p_pwm_gate;
        s_pwm_low |-> sink_on == '0;
    endproperty
    property p_en_low;
        enl_q == 8'(EN_LOW_CYCLES + 6) |-> state inside {BLS_OFF, BLS_STANDBY};
    endproperty
    property p_uv_reset;
        s_supply_low |-> state == BLS_OFF;
    endproperty
    a_off_exit: assert property (p_off_exit) else $error("left off state wrongly");
    a_soft_power: assert property (p_soft_power) else $error("soft start power off");
    a_soft_len: assert property (p_soft_len) else $error("soft start length");
    a_boost_power: assert property (p_boost_power) else $error("boost power wrong");
    a_boost_len: assert property (p_boost_len) else $error("boost length or fault");
    a_start_cause: assert property (p_start_cause) else $error("recovery uncaused");
    a_rec_off: assert property (p_rec_off) else $error("recovery outputs wrong");
    a_rec_len: assert property (p_rec_len) else $error("recovery length");
    a_pwm_gate: assert property (p_pwm_gate) else $error("sinks on with pwm low");
    a_en_low: assert property (p_en_low) else $error("no standby on enable low");
    a_uv_reset: assert property (p_uv_reset) else $error("no reset on low supply");
endmodule

// File: test/bls_host.sv
// host model: drives enable and brightness pins, watches the fault pin
// assumes negedge requests from the bench and a pulled-up fault line
`timescale 1ns/1ps
module bls_host #(
    parameter int unsigned PULSE = 5
) (
    input  wire logic sys_clk,
    input  wire logic enable_req,
    input  wire logic clear_req,
    input  wire logic pwm_lvl,
    input  wire logic fault_line,
    output logic      enable_pin,
    output logic      pwm_pin,
    output logic      fault_seen
);
    int unsigned low_q;
    initial begin
        low_q = 0;
        enable_pin = 1'b0;
        pwm_pin = 1'b0;
        fault_seen = 1'b0;
    end
    // clear pulse holds enable low PULSE+1 cycles, just under the enable-low standby count
    always @(negedge sys_clk) begin
        if (clear_req && low_q == 0) low_q <= PULSE;
        else if (low_q != 0) low_q <= low_q - 1;
        enable_pin <= enable_req && !clear_req && low_q == 0;
        pwm_pin <= pwm_lvl;
        fault_seen <= !fault_line;
    end
endmodule

// File: test/bls_sequencer_tb.sv
// testbench: host stimulus, state-change scoreboard, output checks
// assumes shortened dwell parameters and a 40 MHz clock
`timescale 1ns/1ps
module bls_sequencer_tb
    import bls_pkg::*;
;
    logic sys_clk = 1'b0, rst = 1'b1, supply = 1'b0, en_req = 1'b0, clr = 1'b0, pwm = 1'b0;
    bls_faults_t faults = '0;
    logic [3:0]  gnd = 4'h0, opn = 4'h0, shrt = 4'h0, sink_on, in_loop;
    logic        en_pin, pwm_pin, fault_seen, fault_out, fault_oe_n;
    bls_power_t  power;
    bls_state_t  state, prev;
    bls_state_t  exp_q[$];
    int          n_errors = 0, tests_run = 0;
    logic [31:0] rnd = 32'hD3CFE3D9;
    always #12.5 sys_clk = ~sys_clk;
    bls_sequencer #(.SOFT_CYCLES(20), .BOOST_CYCLES(20), .RECOV_CYCLES(30),
        .EN_LOW_CYCLES(8)) i_bls_sequencer (.sys_clk(sys_clk), .rst(rst),
        .supply_above_uvlo(supply), .enable_and_io_supply_input(en_pin),
        .brightness_pwm(pwm_pin), .faults(faults), .string_grounded(gnd),
        .string_open_fault(opn), .string_short_fault(shrt), .power(power),
        .sink_on(sink_on), .string_in_loop(in_loop), .fault_out(fault_out),
        .fault_oe_n(fault_oe_n), .state(state));
    bls_host i_bls_host (.sys_clk(sys_clk), .enable_req(en_req), .clear_req(clr),
        .pwm_lvl(pwm), .fault_line(fault_oe_n ? 1'b1 : fault_out),
        .enable_pin(en_pin), .pwm_pin(pwm_pin), .fault_seen(fault_seen));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic settle(input int bound);
        for (int i = 0; i < bound && exp_q.size() != 0; i++) @(negedge sys_clk);
        if (exp_q.size() != 0) begin
            n_errors++;
            $display("unexpected at %0t: state wait timed out", $time);
            tally_and_finish();
        end
    endtask
    // =====================================================
    // scoreboard: each state change takes the oldest note
    always @(negedge sys_clk) begin
        prev <= state;
        if (!rst && state !== prev) begin
            if (exp_q.size() == 0) check({1'b0, state}, 4'hF);
            else check({1'b0, state}, {1'b0, exp_q.pop_front()});
        end
    end
    // =====================================================
    // main sequence
    initial begin
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        exp_q = '{BLS_STANDBY};
        supply = 1'b1;
        settle(20);
        gnd = 4'h2;
        exp_q = '{BLS_SOFT_START, BLS_BOOST_START, BLS_NORMAL};
        en_req <= 1'b1;
        settle(80);
        check(in_loop, 4'hD);
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            pwm <= rnd[0];
            repeat (8) @(negedge sys_clk);
            check(sink_on, rnd[0] ? 4'hD : 4'h0);
        end
        pwm <= 1'b1;
        opn = 4'h4;
        shrt = 4'h1;
        repeat (8) @(negedge sys_clk);
        check({3'h0, fault_seen}, 4'h1);
        check(sink_on, 4'h8);
        opn = 4'h0;
        shrt = 4'h0;
        clr <= 1'b1;
        @(negedge sys_clk);
        clr <= 1'b0;
        repeat (14) @(negedge sys_clk);
        check({3'h0, fault_seen}, 4'h0);
        for (int i = 0; i < 5; i++) if (i != 3) begin
            rnd = xs(rnd);
            repeat (rnd[2:0]) @(negedge sys_clk);
            exp_q = '{BLS_RECOVERY};
            faults = bls_faults_t'(5'h01 << i);
            settle(20);
            @(negedge sys_clk);
            check({3'h0, fault_seen}, 4'h1);
            faults = '0;
            exp_q = '{BLS_SOFT_START};
            settle(40);
        end
        faults = bls_faults_t'(5'h01);
        repeat (5) @(negedge sys_clk);
        faults = '0;
        exp_q = '{BLS_BOOST_START, BLS_NORMAL};
        settle(60);
        repeat (4) @(negedge sys_clk);
        check({3'h0, fault_seen}, 4'h0);
        exp_q = '{BLS_STANDBY};
        en_req <= 1'b0;
        settle(30);
        exp_q = '{BLS_SOFT_START};
        en_req <= 1'b1;
        settle(20);
        exp_q = '{BLS_OFF};
        supply = 1'b0;
        settle(20);
        tally_and_finish();
    end
endmodule
bind bls_sequencer bls_sequencer_checker #(.STRINGS(STRINGS), .SOFT_CYCLES(SOFT_CYCLES),
    .BOOST_CYCLES(BOOST_CYCLES), .RECOV_CYCLES(RECOV_CYCLES),
    .EN_LOW_CYCLES(EN_LOW_CYCLES)) i_bls_sequencer_checker (.sys_clk(sys_clk), .rst(rst),
    .supply_above_uvlo(supply_above_uvlo), .brightness_pwm(brightness_pwm),
    .enable_and_io_supply_input(enable_and_io_supply_input), .faults(faults),
    .power(power), .sink_on(sink_on), .fault_oe_n(fault_oe_n), .state(state));
